// *** hw/oap_pkg.sv ***
// Package for the operand address preparation block.
// Assumes one 25 MHz phase clock; consumers use scoped names only.
package oap_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int WORD_W = 32;
    localparam int ADDR_LO = 15;

    // Avalon register word offsets (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_INSTR = 4'h4;
    localparam logic [3:0] REG_INDEX = 4'h8;
    localparam logic [3:0] REG_MEMDATA = 4'hC;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_PADDR = 4'h4;
    localparam logic [3:0] REG_DREG = 4'h8;
    localparam logic [3:0] REG_AREG = 4'hC;
    localparam logic [4:0] REG_RSEL = 5'h10;

    // Control register field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_LOAD = 1;
    localparam int CTRL_MTEST = 2;
    localparam int CTRL_MTRET = 3;
    localparam int CTRL_SIZE_LO = 4;
    localparam int CTRL_CLASS_LO = 8;

    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic [1:0] CNT_RESET = 2'h0;
    localparam logic [3:0] RSEL_RESET = 4'h0;
    localparam int SHIFT_STEP = 8;

    typedef enum logic [2:0] {
        SZ_BYTE = 3'h0,
        SZ_HALF = 3'h1,
        SZ_WORD = 3'h2,
        SZ_DOUBLE = 3'h3,
        SZ_IMMED = 3'h4,
        SZ_SHIFT = 3'h5
    } oap_size_t;

    typedef enum logic [3:0] {
        CL_PLAIN = 4'h0,
        CL_FLOAT = 4'h1,
        CL_LOADABSD = 4'h2,
        CL_STM = 4'h3,
        CL_LDM = 4'h4,
        CL_COMPARE = 4'h5,
        CL_STORE = 4'h6,
        CL_ANALYZE = 4'h7
    } oap_class_t;

    // Gray-coded along idle->p1->p2a->p2b->p3->p4->exec
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_P1 = 3'b001,
        ST_P2A = 3'b011,
        ST_P2B = 3'b010,
        ST_P3 = 3'b110,
        ST_P4 = 3'b111,
        ST_EXEC = 3'b101
    } oap_state_t;

    typedef struct packed {
        logic [3:0] cls;
        logic [2:0] size;
        logic mtest;
        logic load;
    } oap_ctrl_t;

    typedef struct packed {
        logic indirect_flag;
        logic byte_select_high;
        logic byte_select_low;
        logic odd_word_select;
        logic [1:0] shift_counter;
        logic pad_ones_flag;
        logic pad_zeros_flag;
        logic short_clock_inhibit;
        logic busy;
        logic exec;
        logic [2:0] phase;
    } oap_status_t;

endpackage : oap_pkg

// *** hw/oap_core.sv ***
// Operand address preparation: indirect, index alignment, byte counter, padding.
// Assumes an Avalon-MM master supplies instruction, index value and memory words.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module oap_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Phase indications
    output logic prep_phase_one,
    output logic prep_phase_two,
    output logic prep_phase_three,
    output logic prep_phase_four,
    output logic first_execute_phase
);

    oap_pkg::oap_state_t st_q;
    oap_pkg::oap_ctrl_t ctrl_q;
    logic [31:0] instr_q;
    logic [31:0] index_q;
    logic [31:0] mem_q;
    logic [31:0] a_q;
    logic [31:0] d_q;
    logic [31:0] c_q;
    logic [31:0] p_q;
    logic [3:0] rsel_q;
    logic [5:0] shift_amt_q;
    logic shift_left_q;
    logic indirect_flag_q;
    logic index_flag_q;
    logic first_pass_flag_q;
    logic byte_select_high_q;
    logic byte_select_low_q;
    logic odd_word_select_q;
    logic [1:0] shift_counter_q;
    logic pad_ones_flag_q;
    logic pad_zeros_flag_q;
    logic short_clock_inhibit_q;
    logic wait_q;
    logic [31:0] sum;
    logic [31:0] a_aligned;
    logic pre12;
    logic start;
    logic is_byte;
    logic is_half;
    logic is_double;
    logic index_req;
    logic odd_word;
    logic mt_return;
    logic [1:0] cnt_preset;

    assign start = avs_write && !wait_q && avs_address == 5'(oap_pkg::REG_CTRL)
        && avs_writedata[oap_pkg::CTRL_START] && st_q == oap_pkg::ST_IDLE;
    assign is_byte = ctrl_q.size == oap_pkg::SZ_BYTE;
    assign is_half = ctrl_q.size == oap_pkg::SZ_HALF;
    assign is_double = ctrl_q.size == oap_pkg::SZ_DOUBLE;
    assign index_req = instr_q[19:17] != 3'h0 && ctrl_q.size != oap_pkg::SZ_SHIFT;
    assign odd_word = is_double && ctrl_q.cls != oap_pkg::CL_FLOAT && ctrl_q.cls != oap_pkg::CL_LOADABSD;
    assign mt_return = st_q == oap_pkg::ST_EXEC && avs_write && !wait_q && avs_address == 5'(oap_pkg::REG_CTRL)
        && avs_writedata[oap_pkg::CTRL_MTRET] && ctrl_q.mtest;
    assign cnt_preset = is_byte ? ~{byte_select_high_q, byte_select_low_q}
        : (is_half ? (byte_select_high_q ? 2'h0 : 2'h2) : 2'h0);
    // Flags are not yet loaded in phase one, so decode the instruction
    assign pre12 = (st_q == oap_pkg::ST_P1 && !index_req && !instr_q[31])
        || (st_q == oap_pkg::ST_P2B);

    // Index alignment ahead of the addition
    always_comb begin
        a_aligned = a_q;
        if (is_byte) begin
            a_aligned = {2'h0, a_q[31:2]};
        end else if (is_half) begin
            a_aligned = {1'h0, a_q[31:1]};
        end else if (is_double) begin
            a_aligned = {a_q[30:0], 1'h0};
        end
    end

    // Sum bus with padding of the upper half (upper three bytes for byte-size zero padding)
    always_comb begin
        if (index_flag_q) begin
            sum = a_aligned + d_q;
        end else begin
            sum = d_q;
        end
        if (pad_zeros_flag_q) begin
            if (is_byte) begin
                sum[31:8] = 24'h00_0000;
            end else begin
                sum[31:16] = 16'h0000;
            end
        end else if (pad_ones_flag_q) begin
            sum[31:16] = 16'hFFFF;
        end
    end

    // Phase sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q <= oap_pkg::ST_IDLE;
        end else begin
            case (st_q)
                oap_pkg::ST_IDLE: begin
                    if (start) begin
                        st_q <= oap_pkg::ST_P1;
                    end
                end
                oap_pkg::ST_P1: st_q <= pre12 ? oap_pkg::ST_P3 : oap_pkg::ST_P2A;
                oap_pkg::ST_P2A: st_q <= oap_pkg::ST_P2B;
                oap_pkg::ST_P2B: st_q <= oap_pkg::ST_P3;
                oap_pkg::ST_P3: st_q <= (cnt_preset == 2'h0) ? oap_pkg::ST_EXEC : oap_pkg::ST_P4;
                oap_pkg::ST_P4: begin
                    if (shift_counter_q == 2'h0 || shift_counter_q == 2'h1) begin
                        st_q <= oap_pkg::ST_EXEC;
                    end
                end
                oap_pkg::ST_EXEC: begin
                    if (mt_return) begin
                        st_q <= oap_pkg::ST_P4;
                    end else if (avs_write && !wait_q && avs_address == 5'(oap_pkg::REG_CTRL)) begin
                        st_q <= oap_pkg::ST_IDLE;
                    end
                end
                default: st_q <= oap_pkg::ST_IDLE;
            endcase
        end
    end

    // Software registers and Avalon handshake
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q <= '0;
            instr_q <= 32'h0000_0000;
            index_q <= 32'h0000_0000;
            mem_q <= 32'h0000_0000;
            wait_q <= 1'h1;
            avs_readdata <= oap_pkg::UNMAPPED_READ;
        end else begin
            wait_q <= !(avs_read || avs_write) || !wait_q;
            if (avs_write && wait_q) begin
                case (avs_address)
                    5'(oap_pkg::REG_CTRL): begin
                        if (st_q == oap_pkg::ST_IDLE) begin
                            ctrl_q.load <= avs_writedata[oap_pkg::CTRL_LOAD];
                            ctrl_q.mtest <= avs_writedata[oap_pkg::CTRL_MTEST];
                            ctrl_q.size <= avs_writedata[oap_pkg::CTRL_SIZE_LO +: 3];
                            ctrl_q.cls <= avs_writedata[oap_pkg::CTRL_CLASS_LO +: 4];
                        end
                    end
                    5'(oap_pkg::REG_INSTR): instr_q <= avs_writedata;
                    5'(oap_pkg::REG_INDEX): index_q <= avs_writedata;
                    5'(oap_pkg::REG_MEMDATA): mem_q <= avs_writedata;
                    default: ;
                endcase
            end
            if (avs_read && wait_q) begin
                case (avs_address)
                    5'(oap_pkg::REG_STATUS): avs_readdata <= 32'({indirect_flag_q, byte_select_high_q,
                        byte_select_low_q, odd_word_select_q, shift_counter_q, pad_ones_flag_q,
                        pad_zeros_flag_q, short_clock_inhibit_q, st_q != oap_pkg::ST_IDLE,
                        st_q == oap_pkg::ST_EXEC, 2'h0, st_q});
                    5'(oap_pkg::REG_PADDR): avs_readdata <= p_q;
                    5'(oap_pkg::REG_DREG): avs_readdata <= d_q;
                    5'(oap_pkg::REG_AREG): avs_readdata <= a_q;
                    oap_pkg::REG_RSEL: avs_readdata <= {28'h0, rsel_q};
                    default: avs_readdata <= oap_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'h1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && wait_q && avs_waitrequest);
        end
    end

    // Addressing flags
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            indirect_flag_q <= 1'h0;
            index_flag_q <= 1'h0;
            first_pass_flag_q <= 1'h0;
        end else if (start) begin
            indirect_flag_q <= 1'h0;
            index_flag_q <= 1'h0;
            first_pass_flag_q <= 1'h1;
        end else if (st_q == oap_pkg::ST_P1) begin
            indirect_flag_q <= instr_q[31];
            index_flag_q <= index_req;
        end else if (st_q == oap_pkg::ST_P2A) begin
            first_pass_flag_q <= 1'h0;
        end else if (pre12) begin
            index_flag_q <= 1'h0;
        end
    end

    // A, C, D and program address datapath
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            a_q <= 32'h0000_0000;
            c_q <= 32'h0000_0000;
            d_q <= 32'h0000_0000;
            p_q <= 32'h0000_0000;
            shift_amt_q <= 6'h00;
            shift_left_q <= 1'h0;
            rsel_q <= oap_pkg::RSEL_RESET;
        end else begin
            case (st_q)
                oap_pkg::ST_P1: begin
                    d_q <= {17'h0, instr_q[14:0]};
                    rsel_q <= instr_q[23:20];
                    if (is_double) begin
                        d_q[0] <= 1'h0;
                    end
                    if (instr_q[19:17] != 3'h0) begin
                        a_q <= index_q;
                    end
                    if (ctrl_q.size == oap_pkg::SZ_SHIFT && instr_q[19:17] != 3'h0) begin
                        shift_amt_q <= 6'(index_q[5:0] + instr_q[5:0]);
                        shift_left_q <= !index_q[6];
                    end
                end
                oap_pkg::ST_P2A: begin
                    if (indirect_flag_q) begin
                        c_q <= mem_q;
                        d_q <= mem_q;
                    end
                end
                oap_pkg::ST_P2B: begin
                    p_q <= {17'h0, sum[oap_pkg::ADDR_LO - 1:1], is_double ? odd_word : sum[0]};
                end
                oap_pkg::ST_P3: begin
                    d_q <= mem_q;
                    c_q <= mem_q;
                    a_q <= mem_q;
                    if (ctrl_q.cls == oap_pkg::CL_STM) begin
                        p_q <= p_q - 32'h1;
                    end
                    if (ctrl_q.cls == oap_pkg::CL_LDM) begin
                        rsel_q <= rsel_q - 4'h1;
                    end
                end
                oap_pkg::ST_P4: begin
                    if (shift_counter_q != 2'h0) begin
                        if (ctrl_q.load && !ctrl_q.mtest) begin
                            d_q <= d_q >> oap_pkg::SHIFT_STEP;
                        end else begin
                            a_q <= a_q << oap_pkg::SHIFT_STEP;
                        end
                    end
                end
                oap_pkg::ST_EXEC: d_q <= sum;
                default: ;
            endcase
            if (pre12 && st_q == oap_pkg::ST_P1) begin
                p_q <= {17'h0, instr_q[14:1], is_double ? odd_word : instr_q[0]};
            end
        end
    end

    // Byte-select and odd-word flip-flops
    always_ff @(posedge ref_clk) begin
        if (sys_rst || start) begin
            byte_select_high_q <= 1'h0;
            byte_select_low_q <= 1'h0;
            odd_word_select_q <= 1'h0;
        end else begin
            if (st_q == oap_pkg::ST_P1 && index_flag_q == 1'h0 && instr_q[19:17] != 3'h0) begin
                if (is_byte) begin
                    byte_select_high_q <= index_q[1];
                    byte_select_low_q <= index_q[0];
                end else if (is_half) begin
                    byte_select_high_q <= index_q[0];
                end
            end
            if (pre12 && is_double && ctrl_q.cls != oap_pkg::CL_FLOAT
                && ctrl_q.cls != oap_pkg::CL_LOADABSD) begin
                odd_word_select_q <= 1'h1;
            end
        end
    end

    // Byte counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shift_counter_q <= oap_pkg::CNT_RESET;
        end else if (st_q == oap_pkg::ST_P3) begin
            shift_counter_q <= cnt_preset;
        end else if (st_q == oap_pkg::ST_P4 && shift_counter_q != 2'h0) begin
            shift_counter_q <= shift_counter_q - 2'h1;
        end else if (mt_return) begin
            shift_counter_q <= cnt_preset;
        end
    end

    // Sign padding and clock selection
    always_ff @(posedge ref_clk) begin
        if (sys_rst || start) begin
            pad_ones_flag_q <= 1'h0;
            pad_zeros_flag_q <= 1'h0;
            short_clock_inhibit_q <= 1'h1;
        end else begin
            if (st_q == oap_pkg::ST_P3 && ctrl_q.load && is_byte) begin
                pad_zeros_flag_q <= 1'h1;
            end else if (st_q == oap_pkg::ST_P3 && cnt_preset == 2'h0
                && (is_half || ctrl_q.size == oap_pkg::SZ_IMMED)) begin
                pad_ones_flag_q <= mem_q[15];
                pad_zeros_flag_q <= !mem_q[15];
            end else if (st_q == oap_pkg::ST_P4 && shift_counter_q <= 2'h1
                && (is_half || ctrl_q.size == oap_pkg::SZ_IMMED)) begin
                pad_ones_flag_q <= d_q[23];
                pad_zeros_flag_q <= !d_q[23];
            end
            if (((st_q == oap_pkg::ST_P3 && cnt_preset == 2'h0)
                || (st_q == oap_pkg::ST_P4 && shift_counter_q <= 2'h1)) && (ctrl_q.cls == oap_pkg::CL_COMPARE
                || ctrl_q.cls == oap_pkg::CL_STORE || ctrl_q.cls == oap_pkg::CL_ANALYZE)) begin
                short_clock_inhibit_q <= 1'h0;
            end
        end
    end

    // Registered phase outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prep_phase_one <= 1'h0;
            prep_phase_two <= 1'h0;
            prep_phase_three <= 1'h0;
            prep_phase_four <= 1'h0;
            first_execute_phase <= 1'h0;
        end else begin
            prep_phase_one <= st_q == oap_pkg::ST_P1;
            prep_phase_two <= st_q == oap_pkg::ST_P2A || st_q == oap_pkg::ST_P2B;
            prep_phase_three <= st_q == oap_pkg::ST_P3;
            prep_phase_four <= st_q == oap_pkg::ST_P4;
            first_execute_phase <= st_q == oap_pkg::ST_EXEC;
        end
    end

endmodule : oap_core

`default_nettype wire

// *** bench/oap_monitor.sv ***
// Assertion checker for the operand address preparation block.
// Assumes it is bound to oap_core and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module oap_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Phase indications
    input wire logic prep_phase_one,
    input wire logic prep_phase_two,
    input wire logic prep_phase_three,
    input wire logic prep_phase_four,
    input wire logic first_execute_phase
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    wire logic bus_req = avs_read | avs_write;

    AST_WAIT_ANSWER: assert property ($rose(bus_req) |=> !avs_waitrequest)
        else $error("Request not answered one cycle after it rose");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait request low for more than one cycle");
    AST_WAIT_IDLE: assert property (!bus_req |=> avs_waitrequest)
        else $error("Wait request low without a request");
    AST_PHASE_EXCL: assert property ($onehot0({prep_phase_one, prep_phase_two, prep_phase_three,
        prep_phase_four, first_execute_phase})) else $error("Two phases active at once");
    AST_P1_NEXT: assert property (prep_phase_one |=> prep_phase_two || prep_phase_three)
        else $error("Phase one not followed by phase two or three");
    AST_P2_PASSES: assert property ($rose(prep_phase_two) |-> prep_phase_two [*2] ##1 prep_phase_three)
        else $error("Phase two not two passes then phase three");
    AST_P3_NEXT: assert property (prep_phase_three |=> prep_phase_four || first_execute_phase)
        else $error("Phase three not followed by four or execute");
    AST_P4_BOUND: assert property (prep_phase_four |-> ##[1:3] first_execute_phase)
        else $error("Phase four passes exceed the counter range");
    AST_EXEC_FROM: assert property ($rose(first_execute_phase) |->
        $past(prep_phase_three) || $past(prep_phase_four)) else $error("Execute entered from a wrong phase");
    AST_P4_FROM: assert property ($rose(prep_phase_four) |->
        $past(prep_phase_three) || $past(first_execute_phase)) else $error("Phase four entered from a wrong phase");

    COV_INDIRECT: cover property (prep_phase_two [*2]);
    COV_SHIFTS: cover property (prep_phase_four ##1 prep_phase_four ##1 prep_phase_four);
    COV_NO_SHIFT: cover property (prep_phase_three ##1 first_execute_phase);
endmodule : oap_monitor

bind oap_core oap_monitor u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prep_phase_one(prep_phase_one),
    .prep_phase_two(prep_phase_two), .prep_phase_three(prep_phase_three),
    .prep_phase_four(prep_phase_four), .first_execute_phase(first_execute_phase));

`default_nettype wire

// *** bench/oap_mem_model.sv ***
// Core memory and private index registers seen by the block.
// Assumes combinational reads; contents are fixed test patterns.
`timescale 1ns/1ns
`default_nettype none

module oap_mem_model (
    // Core memory port
    input wire logic [14:0] mem_addr,
    output logic [31:0] mem_data,
    // Private register port
    input wire logic [2:0] reg_sel,
    output logic [31:0] reg_data
);
    localparam logic [31:0] XREG [8] = '{32'h3, 32'h4, 32'h5, 32'hD, 32'hA, 32'h2, 32'h0, 32'h7};

    // Pointer word at 0x200, elsewhere address-dependent data
    assign mem_data = (mem_addr == 15'h0200) ? 32'h0000_0300 : 32'h8C4A_2E16 + {17'h0, mem_addr};
    // Register 0 holds data but must never act as an index
    assign reg_data = XREG[reg_sel];
endmodule : oap_mem_model

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the operand address preparation block.
// Assumes oap_pkg, oap_core, the checker and the memory model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic ref_clk;
    logic sys_rst;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ph1, ph2, ph3, ph4, phx;
    logic [14:0] mem_addr;
    logic [31:0] mem_data;
    logic [2:0] reg_sel;
    logic [31:0] reg_data;
    logic [31:0] rd;
    logic [2:0] p4n;
    int failures;
    int comparisons;

    oap_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .prep_phase_one(ph1), .prep_phase_two(ph2),
        .prep_phase_three(ph3), .prep_phase_four(ph4), .first_execute_phase(phx));
    oap_mem_model u_mem (.mem_addr(mem_addr), .mem_data(mem_data), .reg_sel(reg_sel), .reg_data(reg_data));

    initial begin
        ref_clk = 1'b0;
        forever #(oap_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end

    task automatic test_done;
        $display("Counts: failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50) begin
            failures++;
            test_done();
        end
    endtask : bus

    task automatic rdm(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd & mask, exp);
    endtask : rdm

    // Counts phase four passes until execute is reached
    task automatic wait_exec;
        int n;
        p4n = 3'h0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (ph4 === 1'b1) p4n++;
        end while (phx !== 1'b1 && n < 200);
        if (n >= 200) begin
            failures++;
            test_done();
        end
    endtask : wait_exec

    task automatic op(input logic [11:0] ctrl, input logic [2:0] sel, input logic ind, input logic [14:0] ref_a,
                      input logic [14:0] exp_p, input logic [2:0] p4, input logic [2:0] dsel);
        logic [31:0] w;
        logic [31:0] ed;
        reg_sel = sel;
        mem_addr = ind ? ref_a : exp_p;
        bus(1'b1, {1'b0, oap_pkg::REG_CTRL}, 32'h0);
        bus(1'b1, {1'b0, oap_pkg::REG_INSTR}, {ind, 7'h00, 4'h5, sel, 2'h0, ref_a});
        bus(1'b1, {1'b0, oap_pkg::REG_INDEX}, reg_data);
        w = mem_data;
        bus(1'b1, {1'b0, oap_pkg::REG_MEMDATA}, w);
        bus(1'b1, {1'b0, oap_pkg::REG_CTRL}, {20'h0, ctrl} | 32'h1);
        wait_exec();
        if (p4 != 3'h7) chk({29'h0, p4n}, {29'h0, p4});
        rdm({1'b0, oap_pkg::REG_PADDR}, 32'h0000_7FFF, {17'h0, exp_p});
        rdm({1'b0, oap_pkg::REG_STATUS}, 32'h0000_0C00, 32'h0);
        if (ctrl[11:8] == 4'h5) rdm({1'b0, oap_pkg::REG_STATUS}, 32'h0000_0080, 32'h0);
        case (dsel)
            3'h0: ed = {24'h0, w[31:24]};
            3'h1: ed = {24'h0, w[23:16]};
            3'h2: ed = {24'h0, w[15:8]};
            3'h3: ed = {24'h0, w[7:0]};
            3'h4: ed = {{16{w[31]}}, w[31:16]};
            3'h5: ed = {{16{w[15]}}, w[15:0]};
            default: ed = w;
        endcase
        if (dsel != 3'h7) rdm({1'b0, oap_pkg::REG_DREG}, 32'hFFFF_FFFF, ed);
    endtask : op

    initial begin
        failures = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        reg_sel = 3'h0;
        mem_addr = 15'h0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk({27'h0, ph1, ph2, ph3, ph4, phx}, 32'h0);
        rdm({1'b0, oap_pkg::REG_STATUS}, 32'h0000_0C00, {20'h0, oap_pkg::CNT_RESET, 10'h0});
        rdm(oap_pkg::REG_RSEL, 32'h0000_000F, {28'h0, oap_pkg::RSEL_RESET});
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        rdm(5'h14, 32'hFFFF_FFFF, oap_pkg::UNMAPPED_READ);
        op(12'h002, 3'h0, 1'b0, 15'h0100, 15'h0100, 3'h3, 3'h0);
        op(12'h002, 3'h3, 1'b0, 15'h0100, 15'h0103, 3'h2, 3'h1);
        op(12'h002, 3'h4, 1'b0, 15'h0100, 15'h0102, 3'h1, 3'h2);
        op(12'h002, 3'h7, 1'b0, 15'h0100, 15'h0101, 3'h0, 3'h3);
        op(12'h012, 3'h2, 1'b0, 15'h0100, 15'h0102, 3'h0, 3'h5);
        op(12'h012, 3'h0, 1'b0, 15'h0100, 15'h0100, 3'h2, 3'h4);
        op(12'h022, 3'h1, 1'b0, 15'h0100, 15'h0104, 3'h0, 3'h6);
        op(12'h032, 3'h5, 1'b0, 15'h0101, 15'h0105, 3'h7, 3'h7);
        op(12'h132, 3'h5, 1'b0, 15'h0101, 15'h0104, 3'h7, 3'h7);
        op(12'h052, 3'h1, 1'b0, 15'h0100, 15'h0100, 3'h7, 3'h7);
        op(12'h600, 3'h3, 1'b0, 15'h0100, 15'h0103, 3'h2, 3'h7);
        op(12'h522, 3'h0, 1'b0, 15'h0100, 15'h0100, 3'h0, 3'h6);
        op(12'h320, 3'h0, 1'b0, 15'h0100, 15'h00FF, 3'h7, 3'h7);
        op(12'h422, 3'h0, 1'b0, 15'h0100, 15'h0100, 3'h7, 3'h7);
        rdm(oap_pkg::REG_RSEL, 32'h0000_000F, 32'h4);
        op(12'h022, 3'h0, 1'b1, 15'h0200, 15'h0300, 3'h7, 3'h7);
        op(12'h022, 3'h1, 1'b1, 15'h0200, 15'h0304, 3'h7, 3'h7);
        op(12'h004, 3'h3, 1'b0, 15'h0100, 15'h0103, 3'h2, 3'h7);
        bus(1'b1, {1'b0, oap_pkg::REG_CTRL}, 32'h0000_000C);
        wait_exec();
        chk({31'h0, (p4n != 3'h0)}, 32'h1);
        test_done();
    end
endmodule : tb_top

`default_nettype wire
